//--- design/pdrc_top.sv
// power-down, output-enable and initialization control for the sequencer
// registers; the logic arrays sit outside and feed nextRegs, and the
// sequencer clock arrives as a sampled level on seqClkIn
`default_nettype none
// Contract
// RL1: power-down keeps all state and output registers
// RL2: after saving, outputs go high impedance
// RL3: powered down, every input is ignored
// RL4: host should hold inputs static when down
// RL5: first rise after control low is valid
// RL6: edge after power-down request is not valid
// RL7: enable control low drives register data
// RL8: enable control high turns outputs off
// RL9: init forces registers without a clock edge
// RL10: clock edges near init release are ignored
// RL11: power-down mode disables the shared input
// RL12: internal term high overrides external control
// RL13: exit restores outputs per enable control
module pdrc_top
	import pdrc_pkg::*;
#(
	parameter int RW = REG_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire pdrc_cfg_t cfg,
	input wire logic ctlPin,
	input wire logic seqClkIn,
	input wire logic internalInitTermA,
	input wire logic internalInitTermB,
	input wire logic internalOeTermA,
	input wire logic internalOeTermB,
	input wire pdrc_regs_t nextRegs,
	output logic sharedInput,
	output pdrc_regs_t regs,
	output logic [RW-1:0] outPinO,
	output logic [RW-1:0] outPinOe,
	output logic poweredDown
);
	// --------------------------------------------------
	// shared control pin decode
	// --------------------------------------------------
	logic powerDownCtl; // power-down request, active high
	logic extInit; // external init function
	logic extOeOff; // external enable, high means off
	logic [NUM_GRP-1:0] initTerm; // internal init terms
	logic [NUM_GRP-1:0] oeTerm; // internal enable terms
	logic [NUM_GRP-1:0] initReq; // effective init per group
	logic [NUM_GRP-1:0] oeOff; // effective disable per group
	logic [NUM_GRP-1:0] grpLocked; // lockout per group
	logic running; // not in save or down

	assign powerDownCtl = (cfg.pinMode == PIN_PWRDN) && ctlPin; // RL5
	assign extInit = (cfg.pinMode == PIN_INIT) && ctlPin;
	assign extOeOff = (cfg.pinMode == PIN_OE) && ctlPin;
	assign initTerm = {internalInitTermB, internalInitTermA};
	assign oeTerm = {internalOeTermB, internalOeTermA};

	// the pin reaches the logic as a plain input only in input mode
	assign sharedInput = (cfg.pinMode == PIN_INPUT) ? ctlPin : 1'b0; // RL11

	// --------------------------------------------------
	// per-group control selection
	// --------------------------------------------------
	// an internal term configured active high owns the function
	always_comb begin
		for (int g = 0; g < NUM_GRP; g++) begin
			if (cfg.intInitHigh[g]) begin
				initReq[g] = initTerm[g] && running; // RL12 RL3
			end else begin
				initReq[g] = extInit && running; // RL12 RL3
			end
			if (cfg.intOeHigh[g]) begin
				oeOff[g] = oeTerm[g]; // RL12
			end else begin
				oeOff[g] = extOeOff; // RL12
			end
		end
	end

	// --------------------------------------------------
	// power sequencing
	// --------------------------------------------------
	pdrc_pwr_t pwr_r, pwr_nxt; // power state
	logic seqClkPrev_r, seqClkPrev_nxt; // last sampled clock level
	logic clkRise; // rising edge of the sequencer clock
	logic validTick; // rising edge that may load registers

	// next state: one save cycle, then down until request falls
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			PWR_RUN: begin
				if (powerDownCtl) begin
					pwr_nxt = PWR_SAVE;
				end
			end
			PWR_SAVE: begin
				// save cycle always completes so outputs turn off
				pwr_nxt = PWR_DOWN; // RL2
			end
			PWR_DOWN: begin
				if (!powerDownCtl) begin
					pwr_nxt = PWR_RUN; // RL5
				end
			end
			default: begin
				pwr_nxt = PWR_RUN;
			end
		endcase
	end

	// edge tracking keeps sampling so exit sees a true next rise
	assign seqClkPrev_nxt = seqClkIn;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pwr_r <= PWR_RUN;
			seqClkPrev_r <= 1'b0;
		end else begin
			pwr_r <= pwr_nxt;
			seqClkPrev_r <= seqClkPrev_nxt;
		end
	end

	assign running = (pwr_r == PWR_RUN);
	assign clkRise = seqClkIn && !seqClkPrev_r;
	// a pending request disqualifies the edge it precedes
	assign validTick = clkRise && running && !powerDownCtl; // RL6 RL1 RL3
	assign poweredDown = !running;

	// --------------------------------------------------
	// register groups
	// --------------------------------------------------
	generate
		for (genvar g = 0; g < NUM_GRP; g++) begin : gGrp
			pdrc_reg_group #(
				.W(GRP_W),
				.INIT_V(INIT_VAL),
				.RST_V(PRESET_VAL[g*GRP_W +: GRP_W])
			) uGrp (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.tick(validTick),
				.initReq(initReq[g]),
				.nextState(nextRegs.state[g*GRP_W +: GRP_W]),
				.nextOut(nextRegs.out[g*GRP_W +: GRP_W]),
				.stateQ(regs.state[g*GRP_W +: GRP_W]),
				.outQ(regs.out[g*GRP_W +: GRP_W]),
				.locked(grpLocked[g])
			);
			// output pins: data from the register, drive per group
			assign outPinO[g*GRP_W +: GRP_W] = regs.out[g*GRP_W +: GRP_W]; // RL7
			// off when disabled or not running; exit follows enable
			assign outPinOe[g*GRP_W +: GRP_W] =
				{GRP_W{running && !oeOff[g]}}; // RL8 RL2 RL13
		end
	endgenerate

	// --------------------------------------------------
	// checks
	// --------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_down_holds_regs: assert property ( // RL1
		!running && $past(!running) |-> $stable(regs))
		else $error("registers changed while powered down");
	a_save_then_off: assert property ( // RL2
		pwr_r == PWR_SAVE |=> outPinOe == '0 && pwr_r == PWR_DOWN)
		else $error("outputs not off after save");
	a_input_ignored: assert property ( // RL3
		pwr_r == PWR_DOWN && $changed(nextRegs) |=> $stable(regs))
		else $error("input change reached registers while down");
	a_first_rise_loads: assert property ( // RL5
		$past(pwr_r) == PWR_DOWN && running && clkRise && !powerDownCtl
		&& initReq == '0 && grpLocked == '0
		|=> regs == $past(nextRegs))
		else $error("first rise after exit not taken");
	a_request_blocks_edge: assert property ( // RL6
		running && powerDownCtl && initReq == '0 |=> $stable(regs))
		else $error("edge with pending power-down was taken");
	a_enable_drives: assert property ( // RL7
		running && oeOff == '0 |-> outPinOe == '1 && outPinO == regs.out)
		else $error("outputs not driven with register data");
	a_disable_off: assert property ( // RL8
		oeOff[0] |-> outPinOe[GRP_W-1:0] == '0)
		else $error("group a driven while disabled");
	a_init_forces: assert property ( // RL9
		initReq[1] |-> regs.out[RW-1:GRP_W] == INIT_VAL
		##1 (initReq[1] || grpLocked[1]))
		else $error("init did not force group b");
	a_lockout_span: assert property ( // RL10
		$fell(initReq[0]) && running |-> grpLocked[0] [*2]
		##0 $stable(regs.state[GRP_W-1:0]))
		else $error("clock accepted inside init lockout");
	a_shared_gated: assert property ( // RL11
		cfg.pinMode == PIN_PWRDN |-> !sharedInput)
		else $error("shared input active in power-down mode");
	a_internal_owns: assert property ( // RL12
		cfg.intOeHigh[1] && !oeTerm[1] && running |-> outPinOe[RW-1] )
		else $error("external enable not ignored");
	a_exit_follows_oe: assert property ( // RL13
		$past(pwr_r) == PWR_DOWN && running |-> outPinOe[0] == !oeOff[0])
		else $error("exit ignored enable control");
endmodule
`default_nettype wire

//--- inc/pdrc_pkg.sv
// shared constants and types for the power-down / retention control block
// assumes a single 125 MHz system clock and synchronous sampled pins
`default_nettype none
package pdrc_pkg;
	// --------------------------------------------------
	// widths and grouping
	// --------------------------------------------------
	localparam int REG_W = 8; // state and output register width
	localparam int GRP_W = 4; // bits per banked control group
	localparam int NUM_GRP = 2; // two register groups, a and b
	// reset value of every register element: all high
	localparam logic [REG_W-1:0] PRESET_VAL = 8'hff;
	// value forced by the initialization control, per group
	localparam logic [GRP_W-1:0] INIT_VAL = 4'h0;
	// --------------------------------------------------
	// timing
	// --------------------------------------------------
	localparam int CLK_PERIOD_NS = 8; // sys_clk period
	localparam int LOCKOUT_NS = 16; // clock lockout after init release
	// least time, so round up
	localparam int LOCK_CYC = (LOCKOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// --------------------------------------------------
	// types
	// --------------------------------------------------
	// function of the shared control pin
	typedef enum logic [3:0] {
		PIN_INPUT = 4'h1,
		PIN_PWRDN = 4'h2,
		PIN_INIT = 4'h4,
		PIN_OE = 4'h8
	} pdrc_pin_t;
	// power sequencing states
	typedef enum logic [2:0] {
		PWR_RUN = 3'h1,
		PWR_SAVE = 3'h2,
		PWR_DOWN = 3'h4
	} pdrc_pwr_t;
	// static configuration, one bit per group for internal controls
	typedef struct packed {
		pdrc_pin_t pinMode;
		logic [NUM_GRP-1:0] intInitHigh;
		logic [NUM_GRP-1:0] intOeHigh;
	} pdrc_cfg_t;
	// state and output register pair
	typedef struct packed {
		logic [REG_W-1:0] state;
		logic [REG_W-1:0] out;
	} pdrc_regs_t;
endpackage
`default_nettype wire

//--- design/pdrc_reg_group.sv
// one banked group of state and output register bits
// assumes tick is already qualified by power state and pin function
`default_nettype none
module pdrc_reg_group
	import pdrc_pkg::*;
#(
	parameter int W = GRP_W,
	parameter logic [W-1:0] INIT_V = INIT_VAL,
	parameter logic [W-1:0] RST_V = {W{1'b1}}
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic initReq,
	input wire logic [W-1:0] nextState,
	input wire logic [W-1:0] nextOut,
	output logic [W-1:0] stateQ,
	output logic [W-1:0] outQ,
	output logic locked
);
	// --------------------------------------------------
	// storage and lockout
	// --------------------------------------------------
	logic [W-1:0] state_r, state_nxt; // held state bits
	logic [W-1:0] out_r, out_nxt; // held output bits
	logic [3:0] lock_r, lock_nxt; // cycles of clock lockout left

	// next values: init wins, else a running lockout counts down, else a valid tick loads, else hold
	always_comb begin
		state_nxt = state_r;
		out_nxt = out_r;
		lock_nxt = lock_r;
		if (initReq) begin
			// init forces values and rearms the lockout
			state_nxt = INIT_V; // RL9
			out_nxt = INIT_V; // RL9
			lock_nxt = 4'(LOCK_CYC); // RL10
		end else if (lock_r != 4'h0) begin
			// edges near init release are not valid clocks
			lock_nxt = lock_r - 4'h1; // RL10
		end else if (tick) begin
			state_nxt = nextState;
			out_nxt = nextOut;
		end
	end

	// registers only
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= RST_V;
			out_r <= RST_V;
			lock_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			out_r <= out_nxt;
			lock_r <= lock_nxt;
		end
	end

	// init is seen at the outputs with no clock edge
	assign stateQ = initReq ? INIT_V : state_r; // RL9
	assign outQ = initReq ? INIT_V : out_r; // RL9
	assign locked = initReq || (lock_r != 4'h0);
endmodule
`default_nettype wire

//--- verification/pdrc_ctl_model.sv
// controller model that drives the shared control pin
// assumes the bench moves req between clock edges
`default_nettype none
module pdrc_ctl_model (
	input wire logic sys_clk,
	input wire logic req,
	output var logic ctlPin
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------------------------------------------------
	// pin driver
	// --------------------------------------------------
	// low at start: normal operation
	initial ctlPin = 1'b0;
	// moves 1 ns after an edge, so setup to the next edge is ample
	// held steady between requests, never glitched
	always @(posedge sys_clk) begin
		ctlPin <= #1 req;
	end
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the power-down and retention control
// assumes pdrc_pkg and the controller model are compiled first
`default_nettype none
module tb
	import pdrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_n, pdReq, ctlPin, seqClkIn, sharedInput, poweredDown;
	logic initA, initB, internal_oe_term_a, internal_oe_term_b; // internal terms
	pdrc_cfg_t cfg;
	pdrc_regs_t nextRegs, regs;
	logic [7:0] outPinO, outPinOe;
	int err_count, total_checks;
	// --------------------------------------------------
	// clock, model, design
	// --------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	pdrc_ctl_model i_ctl (.sys_clk(sys_clk), .req(pdReq), .ctlPin(ctlPin));
	pdrc_top #(.RW(REG_W)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
		.ctlPin(ctlPin), .seqClkIn(seqClkIn), .internalInitTermA(initA),
		.internalInitTermB(initB), .internalOeTermA(internal_oe_term_a), .internalOeTermB(internal_oe_term_b),
		.nextRegs(nextRegs), .sharedInput(sharedInput), .regs(regs),
		.outPinO(outPinO), .outPinOe(outPinOe), .poweredDown(poweredDown));
	// --------------------------------------------------
	// helpers
	// --------------------------------------------------
	// land 1 ns after the edge, where ctlPin moves; bench drives happen here or 1 ns later
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one sequencer clock rise, then a low sample so rises stay apart
	task automatic tick(input logic [15:0] nv);
		nextRegs = nv;
		seqClkIn = 1'b1;
		cyc(1);
		seqClkIn = 1'b0;
		cyc(1);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// --------------------------------------------------
	// scenarios
	// --------------------------------------------------
	// reset contents and plain loading in input mode
	task automatic t_basic;
		#1;
		chk("regs", 16'hffff, regs);
		chk("oe", 16'h00ff, outPinOe);
		pdReq = 1'b1;
		cyc(1);
		#1;
		chk("shared", 16'h0001, sharedInput);
		pdReq = 1'b0;
		tick(16'h3c5a);
		chk("regs", 16'h3c5a, regs);
		chk("outO", 16'h005a, outPinO);
	endtask
	// entry with a clock rise in the same cycle, toggling while down
	task automatic t_pwrdn;
		cfg.pinMode = PIN_PWRDN;
		cfg.intOeHigh = 2'b10;
		cfg.intInitHigh = 2'b01;
		internal_oe_term_b = 1'b1;
		pdReq = 1'b1;
		cyc(1);
		#1;
		chk("oe", 16'h000f, outPinOe);
		nextRegs = 16'h1234;
		seqClkIn = 1'b1;
		cyc(1);
		#1;
		chk("regs", 16'h3c5a, regs);
		chk("down", 16'h0001, poweredDown);
		chk("oe", 16'h0000, outPinOe);
		chk("shared", 16'h0000, sharedInput);
		seqClkIn = 1'b0;
		cyc(1);
		initA = 1'b1;
		nextRegs = 16'h5555;
		seqClkIn = 1'b1;
		cyc(2);
		chk("regs", 16'h3c5a, regs);
		initA = 1'b0;
		seqClkIn = 1'b0;
		pdReq = 1'b0;
		cyc(2);
		#1;
		chk("down", 16'h0000, poweredDown);
		chk("oe", 16'h000f, outPinOe);
		tick(16'ha5c3);
		chk("regs", 16'ha5c3, regs);
	endtask
	// external pin against internal enable terms
	task automatic t_oe;
		cfg.pinMode = PIN_OE;
		cfg.intOeHigh = 2'b00;
		internal_oe_term_b = 1'b0;
		pdReq = 1'b1;
		cyc(1);
		#1;
		chk("oe", 16'h0000, outPinOe);
		cyc(1);
		cfg.intOeHigh = 2'b01;
		#1;
		chk("oe", 16'h000f, outPinOe);
		pdReq = 1'b0;
		cyc(1);
		internal_oe_term_a = 1'b1;
		#1;
		chk("oe", 16'h00f0, outPinOe);
		cyc(1);
		internal_oe_term_a = 1'b0;
		cfg.intOeHigh = 2'b00;
		#1;
		chk("oe", 16'h00ff, outPinOe);
	endtask
	// forced value without a clock, lockout after release, split groups
	task automatic t_init;
		cfg.pinMode = PIN_INIT;
		cfg.intInitHigh = 2'b00;
		pdReq = 1'b1;
		cyc(1);
		#1;
		chk("regs", 16'h0000, regs);
		pdReq = 1'b0;
		nextRegs = 16'h9696;
		cyc(2);
		seqClkIn = 1'b1;
		cyc(1);
		chk("regs", 16'h0000, regs);
		// a low sample must pass before the next rise counts
		seqClkIn = 1'b0;
		cyc(1);
		tick(16'h9696);
		chk("regs", 16'h9696, regs);
		cfg.intInitHigh = 2'b01;
		pdReq = 1'b1;
		cyc(1);
		#1;
		chk("regs", 16'h0606, regs);
		pdReq = 1'b0;
	endtask
	// --------------------------------------------------
	// main sequence and watchdog
	// --------------------------------------------------
	initial begin
		err_count = 0;
		total_checks = 0;
		rst_n = 1'b0;
		{pdReq, seqClkIn, initA, initB, internal_oe_term_a, internal_oe_term_b} = 6'h00;
		cfg = '{PIN_INPUT, 2'b00, 2'b00};
		nextRegs = 16'h0000;
		cyc(3);
		rst_n = 1'b1;
		t_basic();
		t_pwrdn();
		t_oe();
		t_init();
		end_of_test();
	end
	// run is about 27 cycles; this span is far beyond it
	initial begin
		#20000;
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
